// file: hdl/split_iso_microframe_sched.sv
/*
 per-microframe scheduling and status of a split iso descriptor.
 assumes a transaction engine that offers one microframe result at a time
 and a descriptor store that takes the updated fields; one clock.
*/
// What this block does
// - store bytes received per microframe for IN tokens after a start or complete split in a matching frame
// - software sets complete-split bits; hardware clears each once processed
// - complete-split mask honoured for IN tokens only, ignored for OUT
// - mask bit n executes its split in microframe n
// - eight 3-bit statuses packed, microframe 7 highest, 0 lowest
// - status bit0 transaction error, bit1 babble IN, bit2 underrun OUT
// - software sets start mask bits; hardware clears each after processing
// - OUT sends in microframe only when frame matches and start bit set
// - halt flag set when any microframe reports stall or halt
// - babble summary from status bit1, error summary from status bit0
// - descriptor microframe bits 7 to 3 select the frame
module split_iso_microframe_sched
  import split_iso_descriptor_sched_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire logic                      desc_load,
  input  wire logic [MF_NUM-1:0]         start_split_mask_in,
  input  wire logic [MF_NUM-1:0]         complete_split_mask_in,
  input  wire logic [UFRAME_W-1:0]       desc_uframe,
  input  wire logic                      token_in,
  input  wire logic                      split_phase,
  input  wire logic [FRAME_W-1:0]        bus_frame,
  input  wire logic [2:0]                bus_uframe,
  input  wire logic                      uframe_tick,
  input  wire logic                      res_valid,
  output logic                           res_ready,
  input  wire logic [CNT_W-1:0]          res_count,
  input  wire logic                      res_xact_err,
  input  wire logic                      res_babble,
  input  wire logic                      res_underrun,
  input  wire logic                      res_stall,
  output logic                           split_go,
  output logic [2:0]                     split_go_uframe,
  output logic [MF_NUM-1:0]              start_split_mask,
  output logic [MF_NUM-1:0]              complete_split_mask,
  output logic [MF_NUM*CNT_W-1:0]        rx_counts,
  output logic [MF_NUM*STAT_W-1:0]       mf_result,
  output logic                           halt_flag,
  output logic                           babble_flag,
  output logic                           xact_err_flag
);
  localparam int WORD_W = 3 + CNT_W + STAT_W + 2;

  logic [MF_NUM-1:0]        ss_r, ss_nxt, cs_r, cs_nxt;
  logic [MF_NUM*CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [MF_NUM*STAT_W-1:0] st_r, st_nxt;
  logic                     halt_r, halt_nxt, bab_r, bab_nxt, err_r, err_nxt;
  logic                     go_r, go_nxt, tok_r, tok_nxt;
  logic [2:0]               go_mf_r, go_mf_nxt, pend_mf_r, pend_mf_nxt;
  logic                     pend_r, pend_nxt, pend_cs_r, pend_cs_nxt;
  logic                     pend_ss_r, pend_ss_nxt;
  logic [FRAME_W-1:0]       frame_sel_r, frame_sel_nxt;
  logic                     frame_hit, mask_hit;
  logic                     b_in_valid, b_in_ready, b_out_valid, b_out_ready;
  logic [WORD_W-1:0]        b_in_data, b_out_data;
  logic [2:0]               w_mf, w_stat;
  logic [CNT_W-1:0]         w_cnt;
  logic                     w_cs, w_ss;
  logic [STAT_W-1:0]        new_stat;

  assign frame_hit = (bus_frame == frame_sel_r);
  always_comb begin
    mask_hit = 1'b0;
    if (frame_hit) begin
      if (split_phase == PHASE_SS) begin
        mask_hit = ss_r[bus_uframe];
      end else begin
        mask_hit = (tok_r == TOKEN_IN) && cs_r[bus_uframe];
      end
    end
  end

  // results enter through the buffer; engine stalls on res_ready
  always_comb begin
    new_stat = '0;
    new_stat[STAT_XACT_ERR] = res_xact_err;
    new_stat[STAT_BABBLE]   = res_babble && (tok_r == TOKEN_IN);
    new_stat[STAT_UNDERRUN] = res_underrun && (tok_r == TOKEN_OUT);
    // a result arriving with a new descriptor is the old one's: drop it
    b_in_valid = res_valid && pend_r && !desc_load;
    b_in_data  = {pend_mf_r, res_count, new_stat, pend_ss_r, pend_cs_r};
  end

  mf_skid_buf #(.WIDTH(WORD_W)) u_buf (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (b_in_valid),
    .in_ready  (b_in_ready),
    .in_data   (b_in_data),
    .out_valid (b_out_valid),
    .out_ready (b_out_ready),
    .out_data  (b_out_data)
  );

  assign b_out_ready = 1'b1;
  assign {w_mf, w_cnt, w_stat, w_ss, w_cs} = b_out_data;

  always_comb begin
    ss_nxt = ss_r;
    cs_nxt = cs_r;
    cnt_nxt = cnt_r;
    st_nxt = st_r;
    halt_nxt = halt_r;
    bab_nxt = bab_r;
    err_nxt = err_r;
    tok_nxt = tok_r;
    frame_sel_nxt = frame_sel_r;
    go_nxt = 1'b0;
    go_mf_nxt = go_mf_r;
    pend_nxt = pend_r;
    pend_mf_nxt = pend_mf_r;
    pend_ss_nxt = pend_ss_r;
    pend_cs_nxt = pend_cs_r;
    if (desc_load) begin
      ss_nxt = start_split_mask_in;
      cs_nxt = complete_split_mask_in;
      frame_sel_nxt = desc_uframe[FRAME_MSB:FRAME_LSB];
      tok_nxt = token_in;
      cnt_nxt = {MF_NUM{COUNT_RST}};
      st_nxt = {MF_NUM{STAT_RST}};
      halt_nxt = 1'b0;
      bab_nxt = 1'b0;
      err_nxt = 1'b0;
      pend_nxt = 1'b0;
    end else begin
      if (uframe_tick && mask_hit && !pend_r) begin
        go_nxt = 1'b1;
        go_mf_nxt = bus_uframe;
        pend_nxt = 1'b1;
        pend_mf_nxt = bus_uframe;
        pend_ss_nxt = (split_phase == PHASE_SS);
        pend_cs_nxt = (split_phase == PHASE_CS);
      end
      if (res_valid && res_ready) begin
        pend_nxt = 1'b0;
        halt_nxt = halt_r | res_stall;
      end
      if (b_out_valid) begin
        // only the processed microframe's fields move
        if (w_ss) begin
          ss_nxt[w_mf] = 1'b0;
        end
        if (w_cs) begin
          cs_nxt[w_mf] = 1'b0;
        end
        if ((w_ss && tok_r == TOKEN_OUT) || w_cs || w_ss) begin
          st_nxt[w_mf*STAT_W +: STAT_W] = w_stat;
        end
        if (tok_r == TOKEN_IN) begin
          cnt_nxt[w_mf*CNT_W +: CNT_W] = w_cnt;
        end
        bab_nxt = bab_r | w_stat[STAT_BABBLE];
        err_nxt = err_r | w_stat[STAT_XACT_ERR];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ss_r <= MASK_RST;
      cs_r <= MASK_RST;
      cnt_r <= {MF_NUM{COUNT_RST}};
      st_r <= {MF_NUM{STAT_RST}};
      halt_r <= 1'b0;
      bab_r <= 1'b0;
      err_r <= 1'b0;
      tok_r <= TOKEN_OUT;
      frame_sel_r <= '0;
      go_r <= 1'b0;
      go_mf_r <= 3'h0;
      pend_r <= 1'b0;
      pend_mf_r <= 3'h0;
      pend_ss_r <= 1'b0;
      pend_cs_r <= 1'b0;
    end else begin
      ss_r <= ss_nxt;
      cs_r <= cs_nxt;
      cnt_r <= cnt_nxt;
      st_r <= st_nxt;
      halt_r <= halt_nxt;
      bab_r <= bab_nxt;
      err_r <= err_nxt;
      tok_r <= tok_nxt;
      frame_sel_r <= frame_sel_nxt;
      go_r <= go_nxt;
      go_mf_r <= go_mf_nxt;
      pend_r <= pend_nxt;
      pend_mf_r <= pend_mf_nxt;
      pend_ss_r <= pend_ss_nxt;
      pend_cs_r <= pend_cs_nxt;
    end
  end

  assign res_ready = pend_r;
  assign split_go = go_r;
  assign split_go_uframe = go_mf_r;
  assign start_split_mask = ss_r;
  assign complete_split_mask = cs_r;
  assign rx_counts = cnt_r;
  assign mf_result = st_r;
  assign halt_flag = halt_r;
  assign babble_flag = bab_r;
  assign xact_err_flag = err_r;

  chk_go_needs_frame: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    split_go |-> $past(frame_hit)) else $error("split without frame match");
  chk_out_no_cs: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (split_go && $past(split_phase) == PHASE_CS) |-> tok_r == TOKEN_IN)
    else $error("complete split issued for out");
  chk_go_mask_bit: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (split_go && $past(split_phase) == PHASE_SS) |->
    $past(ss_r[bus_uframe])) else $error("split with clear mask bit");
  chk_halt_sticky: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (res_valid && res_ready && res_stall && !desc_load) |=> halt_flag)
    else $error("halt not set on stall");
  chk_err_summary: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (b_out_valid && w_stat[STAT_XACT_ERR] && !desc_load) |=> xact_err_flag)
    else $error("error summary missed");
  chk_mask_no_set: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !$past(desc_load) |-> (ss_r & ~$past(ss_r)) == '0)
    else $error("hardware set a start bit");
  chk_cs_no_set: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !$past(desc_load) |-> (cs_r & ~$past(cs_r)) == '0)
    else $error("hardware set a complete bit");
  chk_out_no_babble: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (tok_r == TOKEN_OUT) |-> babble_flag == 1'b0)
    else $error("babble on out token");
  // ready comes straight from a flop, so the buffer must always have room
  chk_buf_room: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    pend_r |-> b_in_ready) else $error("result buffer full while pending");
endmodule

// file: include/split_iso_descriptor_sched_pkg.sv
/*
 package for the split iso microframe scheduler: field layout, widths,
 token and status encodings. assumes nothing beyond a SystemVerilog tool.
*/
package split_iso_descriptor_sched_pkg;
  localparam int MF_NUM        = 8;
  localparam int CNT_W         = 8;
  localparam int STAT_W        = 3;
  localparam int FRAME_W       = 5;
  localparam int UFRAME_W      = 8;
  localparam int FRAME_LSB     = 3;
  localparam int FRAME_MSB     = 7;
  localparam int STAT_XACT_ERR = 0;
  localparam int STAT_BABBLE   = 1;
  localparam int STAT_UNDERRUN = 2;
  localparam int IN_SS_LIMIT   = 4;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [2:0] STAT_RST  = 3'h0;
  localparam logic       TOKEN_OUT = 1'b0;
  localparam logic       TOKEN_IN  = 1'b1;
  localparam logic       PHASE_SS  = 1'b0;
  localparam logic       PHASE_CS  = 1'b1;
endpackage

// file: hdl/mf_skid_buf.sv
/*
 two-entry valid/ready buffer for microframe result words.
 assumes one clock and a synchronous active-high reset.
*/
module mf_skid_buf
  import split_iso_descriptor_sched_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot_r [2];
  logic [WIDTH-1:0] slot_nxt [2];
  logic [1:0]       cnt_r, cnt_nxt;
  logic             push, pop;

  always_comb begin
    push = in_valid && (cnt_r != 2'd2);
    pop  = out_valid && out_ready;
    slot_nxt[0] = slot_r[0];
    slot_nxt[1] = slot_r[1];
    cnt_nxt = cnt_r;
    if (pop) begin
      slot_nxt[0] = slot_r[1];
    end
    if (push) begin
      if (cnt_r == 2'd0 || (cnt_r == 2'd1 && pop)) begin
        slot_nxt[0] = in_data;
      end else begin
        slot_nxt[1] = in_data;
      end
    end
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= 2'd0;
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      slot_r[0] <= slot_nxt[0];
      slot_r[1] <= slot_nxt[1];
    end
  end

  // full only at two words, so the producer stalls before anything is lost
  assign in_ready  = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data  = slot_r[0];
endmodule

// file: verification/res_engine_model.sv
/*
 far-side transaction engine model: answers each split with one result.
 assumes split_go pulses once per split and res_ready is sampled at edges.
*/
module res_engine_model (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       split_go,
  input  wire logic       res_ready,
  input  wire logic [3:0] dly,
  input  wire logic [7:0] cnt,
  input  wire logic [3:0] flg,
  output logic            res_valid,
  output logic [7:0]      res_count,
  output logic [3:0]      res_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  logic       busy_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_r    <= 1'b0;
      wait_r    <= 4'h0;
      res_valid <= 1'b0;
      res_count <= 8'h00;
      res_flags <= 4'h0;
    end else if (res_valid && res_ready) begin
      // released data flips so stale values never look valid
      res_valid <= 1'b0;
      res_count <= ~res_count;
      res_flags <= ~res_flags;
    end else if (split_go) begin
      busy_r <= 1'b1;
      wait_r <= dly;
    end else if (busy_r && wait_r == 4'h0) begin
      busy_r    <= 1'b0;
      res_valid <= 1'b1;
      res_count <= cnt;
      res_flags <= flg;
    end else if (busy_r) begin
      wait_r <= wait_r - 4'h1;
    end
  end
endmodule

// file: verification/split_iso_microframe_sched_tb_top.sv
/*
 testbench: loads descriptors, raises microframe ticks, checks fields.
 assumes the engine model answers every split it is given.
*/
module split_iso_microframe_sched_tb_top
  import split_iso_descriptor_sched_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, desc_load = 1'b0;
  logic [7:0]  ss_in = 8'h00, cs_in = 8'h00, desc_uframe = 8'h00;
  logic        token_in = 1'b0, split_phase = 1'b0, uframe_tick = 1'b0;
  logic [4:0]  bus_frame = 5'h00;
  logic [2:0]  bus_uframe = 3'h0, go_uf;
  logic        res_valid, res_ready, split_go;
  logic        halt_flag, babble_flag, xact_err_flag;
  logic [7:0]  res_count, ss, cs, cnt = 8'h00;
  logic [3:0]  res_flags, dly = 4'h0, flg = 4'h0;
  logic [63:0] rx_counts;
  logic [23:0] mf_result;
  int          bad_count = 0, n_compared = 0, cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  split_iso_microframe_sched dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .desc_load(desc_load), .start_split_mask_in(ss_in),
    .complete_split_mask_in(cs_in), .desc_uframe(desc_uframe),
    .token_in(token_in), .split_phase(split_phase), .bus_frame(bus_frame),
    .bus_uframe(bus_uframe), .uframe_tick(uframe_tick),
    .res_valid(res_valid), .res_ready(res_ready), .res_count(res_count),
    .res_xact_err(res_flags[0]), .res_babble(res_flags[1]),
    .res_underrun(res_flags[2]), .res_stall(res_flags[3]),
    .split_go(split_go), .split_go_uframe(go_uf),
    .start_split_mask(ss), .complete_split_mask(cs),
    .rx_counts(rx_counts), .mf_result(mf_result), .halt_flag(halt_flag),
    .babble_flag(babble_flag), .xact_err_flag(xact_err_flag));
  res_engine_model eng (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .split_go(split_go), .res_ready(res_ready), .dly(dly), .cnt(cnt),
    .flg(flg), .res_valid(res_valid), .res_count(res_count),
    .res_flags(res_flags));
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic load(input logic [7:0] s, input logic [7:0] c,
                      input logic [4:0] fr, input logic tok);
    @(posedge clk_sys);
    desc_load   <= 1'b1;
    ss_in       <= s;
    cs_in       <= c;
    desc_uframe <= {fr, 3'h5};
    token_in    <= tok;
    @(posedge clk_sys);
    desc_load <= 1'b0;
    #1;
  endtask
  // one tick; when a split goes, wait for the handshake then the update
  task automatic tick(input logic [4:0] fr, input logic [2:0] uf,
                      input logic ph, input logic go, input logic [3:0] d,
                      input logic [7:0] c, input logic [3:0] f);
    int i;
    dly <= d;
    cnt <= c;
    flg <= f;
    @(posedge clk_sys);
    uframe_tick <= 1'b1;
    bus_frame   <= fr;
    bus_uframe  <= uf;
    split_phase <= ph;
    @(posedge clk_sys);
    uframe_tick <= 1'b0;
    #1;
    chk("split_go", {63'h0, go}, {63'h0, split_go});
    if (go) begin
      chk("split_go_uframe", {61'h0, uf}, {61'h0, go_uf});
      for (i = 0; i < 20; i++) begin
        @(posedge clk_sys);
        if (res_valid && res_ready)
          break;
      end
    end
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk("reset", 64'h0, {ss, cs, halt_flag, babble_flag, xact_err_flag});
    load(8'h01, 8'h04, 5'h05, TOKEN_IN);
    tick(5'h05, 3'h0, PHASE_SS, 1'b1, 4'h0, 8'h2a, 4'h5);
    chk("ss_mask", 64'h0, {56'h0, ss});
    chk("rx_counts", 64'h2a, rx_counts);
    chk("mf_result", 64'h1, {40'h0, mf_result});
    chk("xact_err_flag", 64'h1, {63'h0, xact_err_flag});
    tick(5'h05, 3'h1, PHASE_SS, 1'b0, 4'h0, 8'h77, 4'h1);
    chk("rx_counts", 64'h2a, rx_counts);
    tick(5'h06, 3'h2, PHASE_CS, 1'b0, 4'h0, 8'h77, 4'h2);
    chk("cs_mask", 64'h4, {56'h0, cs});
    tick(5'h05, 3'h2, PHASE_CS, 1'b1, 4'h3, 8'h11, 4'h2);
    chk("cs_mask", 64'h0, {56'h0, cs});
    chk("mf_result", 64'h81, {40'h0, mf_result});
    chk("rx_counts", 64'h11002a, rx_counts);
    chk("babble_flag", 64'h1, {63'h0, babble_flag});
    // new descriptor clears the fields of the old one
    load(8'h80, 8'hff, 5'h03, TOKEN_OUT);
    chk("cleared", 64'h0, {40'h0, mf_result} | rx_counts);
    tick(5'h04, 3'h7, PHASE_SS, 1'b0, 4'h0, 8'h55, 4'hf);
    tick(5'h03, 3'h0, PHASE_CS, 1'b0, 4'h0, 8'h55, 4'hf);
    tick(5'h03, 3'h7, PHASE_SS, 1'b1, 4'h2, 8'h55, 4'hf);
    chk("ss_mask", 64'h0, {56'h0, ss});
    chk("cs_mask", 64'hff, {56'h0, cs});
    chk("mf_result", 64'ha00000, {40'h0, mf_result});
    chk("halt_flag", 64'h1, {63'h0, halt_flag});
    chk("babble_flag", 64'h0, {63'h0, babble_flag});
    chk("xact_err_flag", 64'h1, {63'h0, xact_err_flag});
    complete_run();
  end
endmodule
